//--- logic/ucs_core.sv
// Smart card and address match extension of an asynchronous serial port
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ucs_core import ucs_pkg::*; #(
  parameter bit SC_PRESENT = 1'b1   // Set on the first two port instances
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Character transmitter of the serial core
  output logic             tx_start_r,
  output logic      [8:0]  tx_data_r,
  output logic             tx_last_r,
  input  wire logic        tx_ok,
  input  wire logic        tx_nack,
  // Character receiver of the serial core
  input  wire logic        rx_valid,
  input  wire logic [8:0]  rx_data,
  input  wire logic        rx_rx_parity_fault,
  // Guard and waiting time counters reaching zero
  input  wire logic        gt_zero,
  input  wire logic        wt_zero,
  // Line control and interrupt
  output logic             err_low_r,
  output logic             card_active_r,
  output logic             irq_r
);

  // Inverse convention flips the level and reverses bit order
  function automatic logic [7:0] bit_sense_select_byte(input logic [7:0] d,
                                           input logic inv);
    logic [7:0] r;
    r = d;
    if (inv) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = ~d[7 - i];
      end
    end
    return r;
  endfunction

  // Software visible state
  logic [15:0] admd_r;          // Mask high byte, address low byte
  logic [5:0]  ccon_r;          // Card control bits
  logic [15:0] cint_r;          // Card flags and enables
  logic [2:0]  mode_r;          // Enable, nine-bit, address detect
  logic [8:0]  rxd_r;           // Character at the head
  logic        rx_pf_r;         // Its parity fault
  logic        rx_avail_r;      // Head holds a character
  logic        addressed_r;     // Station was selected
  // Sequencer state
  ucs_tx_t     tx_state_r;
  // One bit wider than the repeat field so code 11 can count to four
  logic [2:0]  tx_rpt_r;        // Retransmits done so far
  logic [2:0]  rx_fail_r;       // Failed receptions so far
  logic [11:0] err_cnt_r;       // Remaining low-drive cycles
  logic [11:0] err_cnt_nxt;

  // Decoded controls
  logic sc_on, t0, nine, wr_cint, rd_rxd, wr_thr;
  logic rx_fault, rx_retry_ev, tx_fail_ev, rx_is_addr, rx_match;
  logic rx_accept;
  logic [2:0] rpt_limit;        // Retransmits the repeat field allows

  assign sc_on   = SC_PRESENT && ccon_r[CC_ON_BIT]
                   && mode_r[MD_EN_BIT];                       // RULE5
  assign t0      = sc_on && !ccon_r[CC_PROT_BIT];              // RULE6
  assign nine    = mode_r[MD_NINE_BIT];
  assign wr_cint = reg_wr && (reg_addr == OFS_CINT) && SC_PRESENT;
  assign rd_rxd  = reg_rd && (reg_addr == OFS_RXD);
  assign wr_thr  = reg_wr && (reg_addr == OFS_THR);

  // Receive side: address characters only count in nine-bit framing
  assign rx_is_addr = mode_r[MD_DET_BIT] && nine && rx_data[8];  // RULE20
  assign rx_match   = ((rx_data[7:0] ^ admd_r[7:0])
                       & admd_r[15:ADMD_MASK_LSB]) == 8'h00; // RULE3 RULE4 RULE22
  // Under T0 a faulty character is repeated by the card until the last try
  assign rx_fault    = rx_valid && rx_rx_parity_fault && t0;
  assign rx_retry_ev = rx_fault && (rx_fail_r == RX_FAIL_LAST);  // RULE10
  // Code 00 still allows one retransmit, so the limit is the field plus one
  assign rpt_limit   = {1'b0, ccon_r[CC_RPT_LSB +: 2]} + 3'h1;    // RULE9
  assign tx_fail_ev  = (tx_state_r == TX_BUSY) && tx_nack && t0
                       && (tx_rpt_r == rpt_limit);                // RULE11
  assign rx_accept   = rx_valid && !(rx_fault && !rx_retry_ev)
                       && (!mode_r[MD_DET_BIT] || !nine
                           || (rx_is_addr ? rx_match : addressed_r));

  // Pull-down length: one or two ETU, loaded on each T0 parity error
  always_comb begin
    err_cnt_nxt = err_cnt_r;
    if (rx_fault) begin
      err_cnt_nxt = ccon_r[CC_LOWLEN_BIT] ? 12'(ETU_CYCLES << 1)
                                          : ETU_CYCLES;       // RULE8
    end else if (err_cnt_r != 12'h000) begin
      err_cnt_nxt = err_cnt_r - 12'h001;
    end
  end

  // Error low-drive counter and line output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_cnt_r <= 12'h000;
      err_low_r <= 1'b0;
    end else begin
      err_cnt_r <= err_cnt_nxt;
      err_low_r <= (err_cnt_nxt != 12'h000);                 // RULE8
    end
  end

  // Control registers written by software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      admd_r <= RST_ADMD;
      ccon_r <= RST_CCON;
      mode_r <= 3'h0;
    end else if (reg_wr) begin
      if (reg_addr == OFS_ADMD) begin
        admd_r <= reg_wdata;
      end
      // Card control only exists where the card logic is built
      if (reg_addr == OFS_CCON && SC_PRESENT) begin
        ccon_r <= reg_wdata[5:0];                            // RULE19
      end
      if (reg_addr == OFS_MODE) begin
        mode_r <= reg_wdata[2:0];
      end
    end
  end

  // Sticky flags: hardware set wins over a software zero in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cint_r <= RST_CINT;
    end else if (SC_PRESENT) begin
      if (wr_cint) begin
        cint_r[7:0] <= reg_wdata[7:0] & CINT_MASK[7:0];
        cint_r[CI_RXRF_BIT] <= cint_r[CI_RXRF_BIT]
                               & reg_wdata[CI_RXRF_BIT];     // RULE23
        cint_r[CI_TXRF_BIT] <= cint_r[CI_TXRF_BIT]
                               & reg_wdata[CI_TXRF_BIT];
        cint_r[CI_WTF_BIT]  <= cint_r[CI_WTF_BIT]
                               & reg_wdata[CI_WTF_BIT];
        cint_r[CI_GTF_BIT]  <= cint_r[CI_GTF_BIT]
                               & reg_wdata[CI_GTF_BIT];
      end
      if (rx_retry_ev) begin
        cint_r[CI_RXRF_BIT] <= 1'b1;                         // RULE10
      end
      if (tx_fail_ev) begin
        cint_r[CI_TXRF_BIT] <= 1'b1;                         // RULE11
      end
      if (wt_zero) begin
        cint_r[CI_WTF_BIT] <= 1'b1;                          // RULE12
      end
      if (gt_zero) begin
        cint_r[CI_GTF_BIT] <= 1'b1;                          // RULE13
      end
    end
  end

  // Receive head, failure count and station selection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_r       <= 9'h000;
      rx_pf_r     <= 1'b0;
      rx_avail_r  <= 1'b0;
      rx_fail_r   <= 3'h0;
      addressed_r <= 1'b0;
    end else begin
      // A new character beats the read that frees the head
      if (rx_accept) begin
        rxd_r      <= {rx_data[8],
                       bit_sense_select_byte(rx_data[7:0],
                                 sc_on && ccon_r[CC_BIT_SENSE_SELECT_BIT])}; // RULE7
        rx_pf_r    <= rx_rx_parity_fault;                               // RULE21
        rx_avail_r <= 1'b1;
      end else if (rd_rxd) begin
        rx_avail_r <= 1'b0;
      end
      // Count consecutive parity failures of one repeated character
      if (rx_valid) begin
        rx_fail_r <= (rx_fault && !rx_retry_ev) ? rx_fail_r + 3'h1
                                                : 3'h0;      // RULE10
      end
      if (rx_valid && rx_is_addr) begin
        addressed_r <= rx_match;                             // RULE22
      end
    end
  end

  // Transmit sequencer with automatic retransmission under T0
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_r <= TX_IDLE;
      tx_start_r <= 1'b0;
      tx_data_r  <= 9'h000;
      tx_last_r  <= 1'b0;
      tx_rpt_r   <= 3'h0;
    end else begin
      tx_start_r <= 1'b0;
      unique case (tx_state_r)
        TX_IDLE: begin
          // Writes while busy are dropped; the busy bit shows it
          if (wr_thr && mode_r[MD_EN_BIT]) begin
            tx_data_r  <= {nine & reg_wdata[THR_NINTH_BIT],
                           bit_sense_select_byte(reg_wdata[7:0],
                                     sc_on && ccon_r[CC_BIT_SENSE_SELECT_BIT])}; // RULE1 RULE7
            tx_last_r  <= SC_PRESENT && reg_wdata[THR_LAST_BIT]; // RULE2
            tx_start_r <= 1'b1;
            tx_rpt_r   <= 3'h0;
            tx_state_r <= TX_BUSY;
          end
        end
        TX_BUSY: begin
          if (tx_ok) begin
            tx_state_r <= TX_IDLE;
          end else if (tx_nack) begin
            if (t0 && !tx_fail_ev) begin
              tx_rpt_r   <= tx_rpt_r + 3'h1;                 // RULE9
              tx_start_r <= 1'b1;
            end else begin
              tx_state_r <= TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Interrupt and status outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r         <= 1'b0;
      card_active_r <= 1'b0;
    end else begin
      card_active_r <= sc_on;
      irq_r <= (t0 && cint_r[CI_PARITY_IRQ_ON_BIT] && rx_avail_r
                && rx_pf_r)                                  // RULE14
            || (t0 && cint_r[CI_RXRIE_BIT]
                && cint_r[CI_RXRF_BIT])                      // RULE15
            || (t0 && cint_r[CI_TXRIE_BIT]
                && cint_r[CI_TXRF_BIT])                      // RULE16
            || (cint_r[CI_WTIE_BIT] && cint_r[CI_WTF_BIT])   // RULE17
            || (cint_r[CI_GTIE_BIT] && cint_r[CI_GTF_BIT]);  // RULE18
    end
  end

  // Read data stands for one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_ADMD: reg_rdata <= admd_r;
        OFS_CCON: reg_rdata <= {10'h000, ccon_r};            // RULE19
        OFS_CINT: reg_rdata <= cint_r & CINT_MASK;
        OFS_MODE: reg_rdata <= 16'h0000
                   | (16'(tx_state_r == TX_BUSY) << MD_BUSY_BIT)
                   | 16'(mode_r);
        OFS_RXD:  reg_rdata <= {rx_pf_r, rx_avail_r, 5'h00, rxd_r};
        default:  reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_THR_CAPTURE: assert property (                          // RULE1
    (wr_thr && tx_state_r == TX_IDLE && mode_r[MD_EN_BIT] && !sc_on)
    |=> tx_start_r && tx_data_r[7:0] == $past(reg_wdata[7:0])
        && tx_data_r[8] == ($past(nine) && $past(reg_wdata[8])))
    else $error("holding write not forwarded");
  AST_LAST_ABSENT: assert property (!SC_PRESENT |-> !tx_last_r) // RULE2
    else $error("last marker on a port without card logic");
  AST_ADDR_MATCH: assert property (                           // RULE3
    (rx_valid && rx_is_addr && rx_match && !rx_fault)
    |=> rx_avail_r && rxd_r[8])
    else $error("matching address character dropped");
  AST_ADDR_MISS: assert property (                            // RULE22
    (rx_valid && rx_is_addr && !rx_match && !rx_avail_r && !rd_rxd)
    |=> !rx_avail_r && !addressed_r)
    else $error("mismatching address character accepted");
  AST_ERR_LEN: assert property (                              // RULE8
    rx_fault |=> err_low_r && err_cnt_r ==
      ($past(ccon_r[CC_LOWLEN_BIT]) ? 12'(ETU_CYCLES << 1) : ETU_CYCLES))
    else $error("wrong pull-down length");
  AST_TX_LIMIT: assert property (                             // RULE9
    $rose(cint_r[CI_TXRF_BIT])
    |-> $past(tx_rpt_r) == $past(rpt_limit))
    else $error("transmit flag before last retransmit");
  AST_RX_FIVE: assert property (                              // RULE10
    $rose(cint_r[CI_RXRF_BIT]) |-> $past(rx_fail_r) == RX_FAIL_LAST)
    else $error("receive flag not on fifth failure");
  AST_WAIT_SET: assert property (                             // RULE12
    (wt_zero && SC_PRESENT) |=> cint_r[CI_WTF_BIT])
    else $error("waiting flag not set");
  AST_GUARD_HOLD: assert property (                           // RULE23
    (cint_r[CI_GTF_BIT] && !(wr_cint && !reg_wdata[CI_GTF_BIT]))
    |=> cint_r[CI_GTF_BIT])
    else $error("guard flag lost without a zero write");
  AST_IRQ_WAIT: assert property (                             // RULE17
    (cint_r[CI_WTF_BIT] && cint_r[CI_WTIE_BIT]) |=> irq_r)
    else $error("waiting interrupt missing");
  AST_NO_CARD: assert property (                              // RULE19
    !SC_PRESENT |-> !err_low_r && cint_r == 16'h0000 && !card_active_r)
    else $error("card logic active on a plain port");

  // Retry sequencing, guard flag and every interrupt source but the waiting one
  AST_TX_RETRY: assert property (                             // RULE9
    (tx_state_r == TX_BUSY && tx_nack && !tx_ok && t0 && !tx_fail_ev)
    |=> tx_start_r && tx_state_r == TX_BUSY)
    else $error("retransmit not started");
  AST_TX_GIVE_UP: assert property (                           // RULE11
    tx_fail_ev |=> cint_r[CI_TXRF_BIT] && tx_state_r == TX_IDLE)
    else $error("transmit flag or idle missing after last retry");
  AST_GUARD_SET: assert property (                            // RULE13
    (gt_zero && SC_PRESENT) |=> cint_r[CI_GTF_BIT])
    else $error("guard flag not set");
  AST_IRQ_PARITY: assert property (                           // RULE14
    (t0 && cint_r[CI_PARITY_IRQ_ON_BIT] && rx_avail_r && rx_pf_r) |=> irq_r)
    else $error("parity interrupt missing");
  AST_IRQ_RX_RPT: assert property (                           // RULE15
    (t0 && cint_r[CI_RXRIE_BIT] && cint_r[CI_RXRF_BIT]) |=> irq_r)
    else $error("receive repeat interrupt missing");
  AST_IRQ_TX_RPT: assert property (                           // RULE16
    (t0 && cint_r[CI_TXRIE_BIT] && cint_r[CI_TXRF_BIT]) |=> irq_r)
    else $error("transmit repeat interrupt missing");
  AST_IRQ_GUARD: assert property (                            // RULE18
    (cint_r[CI_GTF_BIT] && cint_r[CI_GTIE_BIT]) |=> irq_r)
    else $error("guard interrupt missing");

  // Main scenarios the bench is expected to reach
  COV_TX_RETRY: cover property (tx_nack && t0 ##1 tx_start_r);
  COV_RX_FAIL:  cover property (rx_retry_ev);
  COV_ADDR:     cover property (rx_valid && rx_is_addr && rx_match);
  COV_ERR_LOW:  cover property ($rose(err_low_r));

endmodule // ucs_core
`default_nettype wire

//--- logic/ucs_pkg.sv
// Shared constants for the smart card and address match serial extension
// How it works
// (RULE1) Holding register: data 7:0, ninth bit 8
// (RULE2) Bit 15 marks last byte, first ports only
// (RULE3) Mask bit one includes that address bit
// (RULE4) Low byte holds station address for matching
// (RULE5) Card mode needs card enable and port enable
// (RULE6) Protocol bit: zero T0, one T1
// (RULE7) Convention bit: zero direct, one inverse
// (RULE8) Parity error pulls line low 1/2 ETU
// (RULE9) Repeat field gives one to four retransmits
// (RULE10) Receive flag after five failed receptions
// (RULE11) Transmit flag after last retransmit still fails
// (RULE12) Waiting counter zero sets sticky flag
// (RULE13) Guard counter zero sets sticky flag
// (RULE14) Parity enable raises interrupt on parity fault
// (RULE15) Receive repeat enable raises interrupt
// (RULE16) Transmit repeat enable raises interrupt
// (RULE17) Waiting flag interrupts when its enable set
// (RULE18) Guard flag interrupts when its enable set
// (RULE19) Card registers exist only on first ports
// (RULE20) Ninth bit one marks address, nine-bit only
// (RULE21) Parity fault follows character at queue head
// (RULE22) Match compares only bits whose mask is one
// (RULE23) Flags cleared by writing zero, one ignored
package ucs_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] OFS_THR   = 4'h0;
  localparam logic [3:0] OFS_ADMD  = 4'h1;
  localparam logic [3:0] OFS_CCON  = 4'h2;
  localparam logic [3:0] OFS_CINT  = 4'h3;
  localparam logic [3:0] OFS_MODE  = 4'h4;
  localparam logic [3:0] OFS_RXD   = 4'h5;
  // Holding register fields
  localparam int THR_LAST_BIT  = 15;
  localparam int THR_NINTH_BIT = 8;
  // Address match fields
  localparam int ADMD_MASK_LSB = 8;
  // Card control fields
  localparam int CC_ON_BIT     = 0;
  localparam int CC_PROT_BIT   = 1;
  localparam int CC_LOWLEN_BIT = 2;
  localparam int CC_BIT_SENSE_SELECT_BIT   = 3;
  localparam int CC_RPT_LSB    = 4;
  // Card interrupt fields
  localparam int CI_RXRF_BIT   = 13;
  localparam int CI_TXRF_BIT   = 12;
  localparam int CI_WTF_BIT    = 9;
  localparam int CI_GTF_BIT    = 8;
  localparam int CI_PARITY_IRQ_ON_BIT  = 6;
  localparam int CI_RXRIE_BIT  = 5;
  localparam int CI_TXRIE_BIT  = 4;
  localparam int CI_WTIE_BIT   = 1;
  localparam int CI_GTIE_BIT   = 0;
  // Mode register fields
  localparam int MD_EN_BIT     = 0;
  localparam int MD_NINE_BIT   = 1;
  localparam int MD_DET_BIT    = 2;
  localparam int MD_BUSY_BIT   = 8;
  // Receive data register fields
  localparam int RD_AVAIL_BIT  = 14;
  localparam int RD_PF_BIT     = 15;
  // Reset values and writable masks
  localparam logic [15:0] RST_ADMD  = 16'h0000;
  localparam logic [5:0]  RST_CCON  = 6'h00;
  localparam logic [15:0] RST_CINT  = 16'h0000;
  localparam logic [15:0] CCON_MASK = 16'h003F;
  localparam logic [15:0] CINT_MASK = 16'h3373;
  // Timing count in clock cycles and receive failure limit
  localparam logic [11:0] ETU_CYCLES   = 12'h174;
  localparam logic [2:0]  RX_FAIL_LAST = 3'h4;
  // Transmit sequencer states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_BUSY = 2'b10
  } ucs_tx_t;
endpackage

//--- verification/ucs_card_model.sv
// Stand-in for the serial core and card on the far side of the block
`timescale 1ns/1ps
`default_nettype none
module ucs_card_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Transmit side of the core
  input  wire logic       tx_start_r,
  input  wire logic [8:0] tx_data_r,
  output logic            tx_ok,
  output logic            tx_nack,
  // Receive side of the core
  output logic            rx_valid,
  output logic      [8:0] rx_data,
  output logic            rx_rx_parity_fault
);
  int nack_left = 0; // Error answers still to give
  int starts    = 0; // Sends seen since the bench cleared it

  // Answer each send two cycles later, with an error while any remain
  always @(posedge clk) begin
    if (rst_n && tx_start_r) begin
      starts++;
      repeat (2) @(posedge clk);
      if (nack_left > 0) begin // Card reports a line error
        nack_left--;
        tx_nack <= 1'b1;
      end else begin // Clean character
        tx_ok <= 1'b1;
      end
      @(posedge clk);
      tx_ok   <= 1'b0;
      tx_nack <= 1'b0;
    end
  end

  // One character pulse; lines then show the inverse, never a stale value
  task automatic send_char(input logic [8:0] d, input logic pe);
    rx_valid <= 1'b1;
    rx_data  <= d;
    rx_rx_parity_fault  <= pe;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data  <= ~d;
    rx_rx_parity_fault  <= ~pe;
    @(posedge clk);
  endtask

  // Quiet lines at time zero
  initial begin
    tx_ok    = 1'b0;
    tx_nack  = 1'b0;
    rx_valid = 1'b0;
    rx_data  = 9'h000;
    rx_rx_parity_fault  = 1'b0;
  end
endmodule // ucs_card_model
`default_nettype wire

//--- verification/ucs_core_tb.sv
// Self-checking bench for the card and address match extension
`timescale 1ns/1ps
`default_nettype none
module ucs_core_tb import ucs_pkg::*; ;
  logic        clk, rst_n;           // Clock and async reset
  logic [3:0]  reg_addr;             // Register index
  logic [15:0] reg_wdata, reg_rdata; // Register data
  logic        reg_wr, reg_rd;       // Register strobes
  logic        tx_start_r, tx_last_r, tx_ok, tx_nack;
  logic [8:0]  tx_data_r, rx_data;
  logic        rx_valid, rx_rx_parity_fault, gt_zero, wt_zero;
  logic        err_low_r, card_active_r, irq_r;
  int failures  = 0; // Mismatches seen
  int cmp_count = 0; // Comparisons made
  int cycles    = 0; // Cycles run, for the hang guard

  ucs_core u_ucs_core (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_start_r(tx_start_r), .tx_data_r(tx_data_r),
    .tx_last_r(tx_last_r), .tx_ok(tx_ok), .tx_nack(tx_nack),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_rx_parity_fault(rx_rx_parity_fault),
    .gt_zero(gt_zero), .wt_zero(wt_zero), .err_low_r(err_low_r),
    .card_active_r(card_active_r), .irq_r(irq_r));
  ucs_card_model u_card (.clk(clk), .rst_n(rst_n), .tx_start_r(tx_start_r),
    .tx_data_r(tx_data_r), .tx_ok(tx_ok), .tx_nack(tx_nack),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_rx_parity_fault(rx_rx_parity_fault));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, far above the thousand or so cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Strobe then one idle edge, so strobes never reassert in one step
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    v = reg_rdata;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk(v, e);
  endtask

  task automatic irq_is(input logic e);
    chk({15'h0, irq_r}, {15'h0, e});
  endtask

  // Poll the busy bit with a bound
  task automatic wait_idle();
    logic [15:0] v;
    v = 16'hFFFF;
    for (int i = 0; i < 60 && v[MD_BUSY_BIT] !== 1'b0; i++) rd(OFS_MODE, v);
    chk({15'h0, v[MD_BUSY_BIT]}, 16'h0000);
  endtask

  task automatic t_regs();
    rchk(OFS_ADMD, RST_ADMD);
    rchk(OFS_CCON, 16'h0000);
    rchk(OFS_CINT, RST_CINT);
    wr(OFS_ADMD, 16'hF0A5);
    rchk(OFS_ADMD, 16'hF0A5);
    wr(OFS_CCON, 16'hFFFF);
    rchk(OFS_CCON, 16'h003F);
    wr(OFS_CINT, 16'hFFFF);
    rchk(OFS_CINT, 16'h0073);
    rchk(OFS_THR, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rchk(4'hF, 16'h0000);
    chk({15'h0, card_active_r}, 16'h0000);
    wr(OFS_MODE, 16'h0001);
    @(posedge clk);
    chk({15'h0, card_active_r}, 16'h0001);
    wr(OFS_CCON, 16'h0000);
    wr(OFS_CINT, 16'h0000);
  endtask

  // Card mode off: fields pass, a write while busy is dropped
  task automatic t_plain_tx();
    wr(OFS_MODE, 16'h0003);
    u_card.starts = 0;
    wr(OFS_THR, 16'h8155);
    chk({15'h0, tx_start_r}, 16'h0001);
    chk({7'h0, tx_data_r}, 16'h0155);
    chk({15'h0, tx_last_r}, 16'h0001);
    wr(OFS_THR, 16'h0011);
    wait_idle();
    chk(16'(u_card.starts), 16'h0001);
    wr(OFS_MODE, 16'h0001);
    wr(OFS_THR, 16'h0155);
    chk({7'h0, tx_data_r}, 16'h0055);
    wait_idle();
  endtask

  // T=0 retries for every repeat code; inverse sense on 13h gives 37h
  task automatic t_retry();
    for (int r = 0; r < 4; r++) begin
      u_card.nack_left = 8;
      u_card.starts = 0;
      wr(OFS_CINT, 16'h0010);
      wr(OFS_CCON, 16'(r << CC_RPT_LSB) | 16'h0009);
      wr(OFS_THR, 16'h0013);
      chk({7'h0, tx_data_r}, 16'h0037);
      wait_idle();
      chk(16'(u_card.starts), 16'(r + 2));
      rchk(OFS_CINT, 16'h1010);
      irq_is(1'b1);
      wr(OFS_CINT, 16'h0010);
      @(posedge clk);
      irq_is(1'b0);
    end
    // T=1 ignores the repeat field
    u_card.nack_left = 1;
    u_card.starts = 0;
    wr(OFS_CCON, 16'h0033);
    wr(OFS_THR, 16'h0013);
    wait_idle();
    chk(16'(u_card.starts), 16'h0001);
    rchk(OFS_CINT, 16'h0010);
  endtask

  // Five bad receptions under T=0 with a two-unit pull-down
  task automatic t_rx_fault();
    int n;
    n = 0;
    wr(OFS_CCON, 16'h0005);
    wr(OFS_CINT, 16'h0020);
    u_card.send_char(9'h0C3, 1'b1);
    while (err_low_r === 1'b1 && n < 2000) begin
      n++;
      @(posedge clk);
    end
    chk(16'(n), 16'(2 * ETU_CYCLES));
    rchk(OFS_RXD, 16'h0000);
    repeat (4) u_card.send_char(9'h0C3, 1'b1);
    repeat (2) @(posedge clk);
    irq_is(1'b1);
    rchk(OFS_CINT, 16'h2020);
    wr(OFS_CINT, 16'h0040);
    @(posedge clk);
    irq_is(1'b1);
    rchk(OFS_RXD, 16'hC0C3);
    @(posedge clk);
    irq_is(1'b0);
  endtask

  // Station F0A5: high nibble compared, low nibble masked out
  task automatic t_addr();
    logic [15:0] v;
    wr(OFS_CCON, 16'h0000);
    wr(OFS_CINT, 16'h0000);
    wr(OFS_MODE, 16'h0007);
    u_card.send_char(9'h1A3, 1'b0);
    u_card.send_char(9'h042, 1'b0);
    rchk(OFS_RXD, 16'h4042);
    u_card.send_char(9'h1B5, 1'b0);
    u_card.send_char(9'h077, 1'b0);
    rd(OFS_RXD, v);
    chk({15'h0, v[RD_AVAIL_BIT]}, 16'h0000);
    wr(OFS_MODE, 16'h0005);
    u_card.send_char(9'h066, 1'b0);
    rchk(OFS_RXD, 16'h4066);
  endtask

  // Counter zero pulses, sticky flags and their enables
  task automatic t_timers();
    wr(OFS_CINT, 16'h0002);
    wt_zero <= 1'b1;
    @(posedge clk);
    wt_zero <= 1'b0;
    repeat (2) @(posedge clk);
    irq_is(1'b1);
    rchk(OFS_CINT, 16'h0202);
    gt_zero <= 1'b1;
    @(posedge clk);
    gt_zero <= 1'b0;
    rchk(OFS_CINT, 16'h0302);
    wr(OFS_CINT, 16'h0301);
    @(posedge clk);
    irq_is(1'b1);
    wr(OFS_CINT, 16'h0201);
    @(posedge clk);
    irq_is(1'b0);
    rchk(OFS_CINT, 16'h0201);
  endtask

  // Main sequence
  initial begin
    rst_n     = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    gt_zero   = 1'b0;
    wt_zero   = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_plain_tx();
    t_retry();
    t_rx_fault();
    t_addr();
    t_timers();
    print_verdict();
  end
endmodule // ucs_core_tb
`default_nettype wire
